//--- hw/ccr_regs.sv
// charger configuration registers 0x04..0x07 and their timers
// assumes all status inputs come from logic on mclk
`timescale 1ns/1ps
module ccr_regs #(
  parameter int MS_CYCLES   = ccr_pkg::CCR_MS_CYCLES,
  parameter int SEC_MS      = ccr_pkg::CCR_SEC_MS,
  parameter int SHIP_MS     = ccr_pkg::CCR_SHIP_DELAY_MS,
  parameter int SAFE_SHORT_S = ccr_pkg::CCR_SAFE_SHORT_H * ccr_pkg::CCR_HOUR_S,
  parameter int SAFE_LONG_S  = ccr_pkg::CCR_SAFE_LONG_H * ccr_pkg::CCR_HOUR_S
)(
  input  logic        mclk,
  input  logic        reset_n,
  input  logic        reg_reset,
  input  logic [7:0]  reg_addr,
  input  logic        reg_wr,
  input  logic        reg_rd,
  input  logic [7:0]  reg_wdata,
  output logic [7:0]  reg_rdata,
  input  logic        host_timeout_kick,
  output logic        host_timeout_kick_clear,
  output logic        host_timeout_expired,
  input  logic [15:0] batt_mv,
  input  logic        charge_done,
  output logic        recharge_start,
  input  logic        term_condition,
  output logic        term_detected,
  input  logic        direct_charge_path_enable,
  input  logic        input_bus_overcurrent,
  output logic        path_clear_req,
  input  logic        charging_active,
  input  logic        dynamic_power_limiting,
  input  logic        cool_zone,
  input  logic        thermal_regulating,
  output logic        safety_timer_expired,
  output logic [7:0]  thermal_limit_c,
  input  logic        cold_zone,
  input  logic        cold_current_scale_enable,
  input  logic [11:0] fast_charge_current,
  output logic [11:0] charge_current_limit,
  output logic [15:0] input_overvoltage_mv,
  output logic [15:0] boost_output_mv,
  input  logic        warm_zone,
  output logic [15:0] charge_voltage_mv,
  input  logic [1:0]  input_voltage_floor_offset_sel,
  output logic [15:0] input_voltage_floor_mv,
  input  logic        vbus_present,
  input  logic        input_limit_detect_done,
  output logic        input_limit_detect_run,
  output logic        battery_switch_on
);
  import ccr_pkg::*;

  // refuse counts the counters cannot hold
  if (MS_CYCLES < 2 || MS_CYCLES > 131071 || SEC_MS < 2 || SEC_MS > 1023)
    $error("ccr_regs: tick parameters out of range");
  if (SHIP_MS < 1 || SHIP_MS > 16383 || SAFE_LONG_S > 131071 || SAFE_SHORT_S < 1)
    $error("ccr_regs: delay parameters out of range");

  typedef struct packed {
    logic [3:0][7:0] r;        // the four registers
    logic [7:0]      rdata;    // read data
    logic [16:0]     ms_div;   // cycle divider
    logic [9:0]      sec_div;  // ms divider
    logic [7:0]      wd_cnt;   // host timeout seconds
    logic            wd_exp;   // expiry pulse
    logic            kick_clr; // kick acknowledge
    logic [7:0]      term_cnt; // termination ms
    logic            term_done;
    logic [16:0]     safe_cnt; // safety seconds
    logic            half;     // half rate phase
    logic            safe_exp;
    logic [13:0]     ship_cnt; // ship entry ms
    logic            bsw_on;   // battery switch
  } ccr_state_t;

  ccr_state_t s_reg;
  ccr_state_t s_next;
  logic        ms_tick;    // one cycle per ms
  logic        sec_tick;   // one cycle per second
  logic        in_range;   // address hits the bank
  logic [1:0]  idx;        // register index
  logic [4:0]  vcode;      // clamped voltage code
  logic [15:0] vprog;      // programmed limit
  logic [15:0] floor_base; // register floor
  logic [15:0] floor_trk;  // tracking floor
  logic [7:0]  term_lim;   // termination filter ms
  logic [16:0] safe_lim;   // safety limit seconds
  logic        slow;       // safety timer slowed

  assign ms_tick  = (s_reg.ms_div == 17'(MS_CYCLES - 1));
  assign sec_tick = ms_tick && (s_reg.sec_div == 10'(SEC_MS - 1));
  assign in_range = (reg_addr >= CCR_OFS_FIRST) && (reg_addr <= CCR_OFS_LAST);
  assign idx      = 2'(reg_addr - CCR_OFS_FIRST);

  // voltage code decode with clamp and the special code
  assign vcode = (s_reg.r[CCR_I_VLIM][7:3] > CCR_CHARGE_VOLTAGE_CODE_MAXC) ? CCR_CHARGE_VOLTAGE_CODE_MAXC
                 : s_reg.r[CCR_I_VLIM][7:3];
  assign vprog = (vcode == CCR_CHARGE_VOLTAGE_CODE_SPEC) ? CCR_CHARGE_VOLTAGE_CODE_SPMV
                 : 16'(CCR_CHARGE_VOLTAGE_CODE_BASE + CCR_CHARGE_VOLTAGE_CODE_STEP * 16'(vcode));

  // warm zone picks the lower of the fixed cap and the limit
  assign charge_voltage_mv = (warm_zone && !s_reg.r[CCR_I_CTL4][CCR_B_WARM]
                              && vprog > CCR_WARM_MV) ? CCR_WARM_MV : vprog;

  // recharge when a full battery sags below limit minus delta
  assign recharge_start = charge_done && (batt_mv < 16'(vprog
                          - (s_reg.r[CCR_I_VLIM][CCR_B_RECHG] ? CCR_RECHG_HI
                             : CCR_RECHG_LO)));

  // shared bit: over-current clear gate while the path is on
  assign path_clear_req = direct_charge_path_enable && input_bus_overcurrent
                          && !s_reg.r[CCR_I_CTL2][CCR_B_SHARED];
  // shared bit: filter length while the path is off
  assign term_lim = (!direct_charge_path_enable && s_reg.r[CCR_I_CTL2][CCR_B_SHARED])
                    ? CCR_TERM_SHORT_MS : CCR_TERM_LONG_MS;

  assign thermal_limit_c = s_reg.r[CCR_I_CTL2][CCR_B_THERM] ? CCR_THERMAL_LIMIT_SEL_HI_C
                           : CCR_THERMAL_LIMIT_SEL_LO_C;

  // cold zone scaling; a constant divide keeps it cheap
  always_comb
  begin
    if (cold_zone && cold_current_scale_enable)
      charge_current_limit = s_reg.r[CCR_I_CTL2][CCR_B_COLD]
                             ? 12'(fast_charge_current / 12'h005)
                             : 12'(fast_charge_current >> 1);
    else
      charge_current_limit = fast_charge_current;
  end

  assign input_overvoltage_mv = CCR_OVP_MV[s_reg.r[CCR_I_CTL3][7:6]];
  assign boost_output_mv      = CCR_BST_MV[s_reg.r[CCR_I_CTL3][5:4]];

  // floor: offset plus steps, raised by battery tracking
  assign floor_base = 16'(CCR_FOFS_MV[input_voltage_floor_offset_sel]
                      + CCR_FLOOR_STEP * 16'(s_reg.r[CCR_I_CTL3][3:0]));
  assign floor_trk  = 16'(batt_mv + CCR_TRK_MV[s_reg.r[CCR_I_CTL4][1:0]]);
  assign input_voltage_floor_mv = (s_reg.r[CCR_I_CTL4][1:0] != 2'h0
                                   && floor_trk > floor_base) ? floor_trk
                                  : floor_base;

  // detection runs only with input present
  assign input_limit_detect_run = s_reg.r[CCR_I_CTL4][CCR_B_ILIM] && vbus_present;

  assign safe_lim = s_reg.r[CCR_I_CTL2][CCR_B_SLEN] ? 17'(SAFE_LONG_S)
                    : 17'(SAFE_SHORT_S);
  assign slow = s_reg.r[CCR_I_CTL4][CCR_B_HALF] && (dynamic_power_limiting
                || cool_zone || thermal_regulating);

  assign reg_rdata               = s_reg.rdata;
  assign host_timeout_kick_clear = s_reg.kick_clr;
  assign host_timeout_expired    = s_reg.wd_exp;
  assign term_detected           = s_reg.term_done;
  assign safety_timer_expired    = s_reg.safe_exp;
  assign battery_switch_on       = s_reg.bsw_on;

  // next state of everything
  always_comb
  begin
    s_next = s_reg;
    s_next.wd_exp = 1'b0;
    s_next.kick_clr = 1'b0;
    // dividers
    s_next.ms_div = ms_tick ? 17'h0 : 17'(s_reg.ms_div + 17'h1);
    if (sec_tick)
      s_next.sec_div = 10'h0;
    else if (ms_tick)
      s_next.sec_div = 10'(s_reg.sec_div + 10'h1);
    // host timeout: kick restarts, code 00 holds it
    if (host_timeout_kick)
    begin
      s_next.wd_cnt = 8'h0;
      s_next.kick_clr = 1'b1;
    end
    else if (s_reg.r[CCR_I_CTL2][5:4] == 2'h0)
      s_next.wd_cnt = 8'h0;
    else if (sec_tick)
    begin
      if (8'(s_reg.wd_cnt + 8'h1) >= CCR_WD_S[s_reg.r[CCR_I_CTL2][5:4]])
      begin
        s_next.wd_cnt = 8'h0;
        s_next.wd_exp = 1'b1;
      end
      else
        s_next.wd_cnt = 8'(s_reg.wd_cnt + 8'h1);
    end
    // expiry restores only its own fields
    if (s_reg.wd_exp)
      for (int i = 0; i < 4; i++)
        s_next.r[i] = (s_reg.r[i] & ~CCR_WD_MASK[i])
                      | (CCR_RST[i] & CCR_WD_MASK[i]);
    // detection done clears the force bit; a host write below still wins
    if (input_limit_detect_done)
      s_next.r[CCR_I_CTL4][CCR_B_ILIM] = 1'b0;
    // host write
    if (reg_wr && in_range)
      s_next.r[idx] = reg_wdata;
    // read data, unmapped reads as zero
    if (reg_rd)
      s_next.rdata = in_range ? s_reg.r[idx] : 8'h0;
    // termination filter; held off while disabled
    if (!term_condition || !s_reg.r[CCR_I_CTL2][CCR_B_TERM])
    begin
      s_next.term_cnt = 8'h0;
      s_next.term_done = 1'b0;
    end
    else if (ms_tick && !s_reg.term_done)
    begin
      if (8'(s_reg.term_cnt + 8'h1) >= term_lim)
        s_next.term_done = 1'b1;
      else
        s_next.term_cnt = 8'(s_reg.term_cnt + 8'h1);
    end
    // safety timer over pre and fast charge
    if (!charging_active || !s_reg.r[CCR_I_CTL2][CCR_B_SAFE])
    begin
      s_next.safe_cnt = 17'h0;
      s_next.half = 1'b0;
      s_next.safe_exp = 1'b0;
    end
    else if (sec_tick && !s_reg.safe_exp)
    begin
      s_next.half = slow ? !s_reg.half : 1'b0;
      if (!slow || s_reg.half)
      begin
        s_next.safe_cnt = 17'(s_reg.safe_cnt + 17'h1);
        if (17'(s_reg.safe_cnt + 17'h1) >= safe_lim)
          s_next.safe_exp = 1'b1;
      end
    end
    // battery switch; clearing the disable aborts the delay
    if (!s_reg.r[CCR_I_CTL4][CCR_B_BSDIS])
    begin
      s_next.ship_cnt = 14'h0;
      s_next.bsw_on = 1'b1;
    end
    else if (!s_reg.r[CCR_I_CTL4][CCR_B_BSDLY])
      s_next.bsw_on = 1'b0;
    else if (s_reg.bsw_on && ms_tick)
    begin
      if (14'(s_reg.ship_cnt + 14'h1) >= 14'(SHIP_MS))
        s_next.bsw_on = 1'b0;
      else
        s_next.ship_cnt = 14'(s_reg.ship_cnt + 14'h1);
    end
    // register reset restores every field
    if (reg_reset)
      s_next.r = CCR_RST;
    // synchronous reset
    if (!reset_n)
    begin
      s_next = '0;
      s_next.r = CCR_RST;
      s_next.bsw_on = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge mclk)
  begin
    s_reg <= s_next;
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_CHARGE_VOLTAGE_CODE_CLAMP: assert property (s_reg.r[0][7:3] > 5'h18 |-> vprog == 16'h1210)
    else $error("clamped code not at maximum");
  AST_CHARGE_VOLTAGE_CODE_SPEC: assert property (s_reg.r[0][7:3] == 5'h0f |-> vprog == 16'h1100)
    else $error("special code wrong");
  AST_CHARGE_VOLTAGE_CODE_LIN: assert property (s_reg.r[0][7:3] == 5'h0b |-> vprog == 16'h1070)
    else $error("default code not 4208 mV");
  AST_KICK: assert property (host_timeout_kick |=> s_reg.wd_cnt == 8'h0 && s_reg.kick_clr)
    else $error("kick did not restart timer");
  AST_WD_KEEP: assert property (s_reg.wd_exp && !reg_wr && !reg_reset
                                |=> s_reg.r[2] == $past(s_reg.r[2]))
    else $error("expiry touched a register-reset field");
  AST_WD_DEF: assert property (s_reg.wd_exp && !reg_wr && !reg_reset |=> s_reg.r[1] == 8'h9f)
    else $error("expiry did not restore control two");
  AST_TERM_OFF: assert property (!s_reg.r[1][7] |=> !term_detected)
    else $error("termination while disabled");
  AST_BSW_NOW: assert property ($rose(s_reg.r[3][5]) && !s_reg.r[3][3] && !reg_reset
                                |=> !battery_switch_on)
    else $error("switch not off at once");
  AST_BSW_WAIT: assert property ($rose(s_reg.r[3][5]) && s_reg.r[3][3] && !reg_reset
                                 && !reg_wr |-> battery_switch_on [*2])
    else $error("switch off before delay");
  AST_ILIM_CLR: assert property (input_limit_detect_done && !reg_wr && !reg_reset
                                 |=> !s_reg.r[3][7])
    else $error("force bit not cleared");
  AST_PATH: assert property (path_clear_req |-> !s_reg.r[1][6]
                             && direct_charge_path_enable)
    else $error("clear request while forbidden");
  // a disabled safety timer must never report expiry
  AST_SAFE_OFF: assert property (!s_reg.r[1][3] |=> !safety_timer_expired)
    else $error("safety timer expired while disabled");
  // warm zone with the cap selected never exceeds 4100 mV
  AST_WARM_CAP: assert property (warm_zone && !s_reg.r[3][4]
                                 |-> charge_voltage_mv <= 16'h1004)
    else $error("warm zone voltage above cap");
  // forced detection needs input power present
  AST_RUN_GATE: assert property (!vbus_present |-> !input_limit_detect_run)
    else $error("detection runs without input");

  COV_EXPIRE: cover property (s_reg.wd_exp);
  COV_TERM: cover property (term_detected);
  COV_SHIP: cover property ($fell(battery_switch_on));
  COV_SAFE: cover property (safety_timer_expired);
endmodule

//--- hw/ccr_pkg.sv
// constants of the charger configuration register bank
// assumes a 125 MHz mclk and a byte-wide register port
package ccr_pkg;
  localparam logic [7:0]      CCR_OFS_FIRST = 8'h04; // voltage limit register
  localparam logic [7:0]      CCR_OFS_LAST  = 8'h07; // control register four
  // reset values, index 0 is offset 0x04
  localparam logic [3:0][7:0] CCR_RST = {8'h4c, 8'he6, 8'h9f, 8'h58};
  // fields restored on timeout expiry
  localparam logic [3:0][7:0] CCR_WD_MASK = {8'hd4, 8'h00, 8'hff, 8'hff};
  localparam int CCR_I_VLIM = 0;
  localparam int CCR_I_CTL2 = 1;
  localparam int CCR_I_CTL3 = 2;
  localparam int CCR_I_CTL4 = 3;
  // bit positions
  localparam int CCR_B_RECHG  = 0; // recharge_threshold_sel
  localparam int CCR_B_TERM   = 7; // termination enable
  localparam int CCR_B_SHARED = 6; // path_clear_or_term_timer_sel
  localparam int CCR_B_SAFE   = 3; // safety timer enable
  localparam int CCR_B_SLEN   = 2; // safety_timer_length_sel
  localparam int CCR_B_THERM  = 1; // thermal_limit_sel
  localparam int CCR_B_COLD   = 0; // cold_current_scale_sel
  localparam int CCR_B_ILIM   = 7; // input_limit_detect_force
  localparam int CCR_B_HALF   = 6; // half_rate_timer_enable
  localparam int CCR_B_BSDIS  = 5; // battery_switch_disable
  localparam int CCR_B_WARM   = 4; // warm_voltage_sel
  localparam int CCR_B_BSDLY  = 3; // battery_switch_delay_sel
  // voltages in mV, thermal limits in degrees C
  localparam logic [15:0] CCR_CHARGE_VOLTAGE_CODE_BASE = 16'h0f10; // 3856
  localparam logic [15:0] CCR_CHARGE_VOLTAGE_CODE_STEP = 16'h0020; // 32
  localparam logic [4:0]  CCR_CHARGE_VOLTAGE_CODE_MAXC = 5'h18;
  localparam logic [4:0]  CCR_CHARGE_VOLTAGE_CODE_SPEC = 5'h0f;
  localparam logic [15:0] CCR_CHARGE_VOLTAGE_CODE_SPMV = 16'h1100; // 4352
  localparam logic [15:0] CCR_CHARGE_VOLTAGE_CODE_CLMV = 16'h1210; // 4624
  localparam logic [15:0] CCR_WARM_MV   = 16'h1004; // 4100
  localparam logic [15:0] CCR_RECHG_HI  = 16'h00c8; // 200
  localparam logic [15:0] CCR_RECHG_LO  = 16'h0064; // 100
  localparam logic [15:0] CCR_FLOOR_STEP = 16'h0064; // 100 per count
  localparam logic [3:0][15:0] CCR_OVP_MV = {16'h36b0, 16'h2904, 16'h1964, 16'h157c};
  localparam logic [3:0][15:0] CCR_BST_MV = {16'h14b4, 16'h141e, 16'h1388, 16'h12f2};
  localparam logic [3:0][15:0] CCR_FOFS_MV = {16'h2904, 16'h1d4c, 16'h170c, 16'h0f3c};
  localparam logic [3:0][15:0] CCR_TRK_MV = {16'h012c, 16'h00fa, 16'h00c8, 16'h0000};
  localparam logic [7:0] CCR_THERMAL_LIMIT_SEL_LO_C = 8'h50; // 80
  localparam logic [7:0] CCR_THERMAL_LIMIT_SEL_HI_C = 8'h78; // 120
  // times
  localparam int CCR_CLK_PS = 8000;
  localparam int CCR_MS_PS = 1000000000;
  localparam int CCR_MS_CYCLES = CCR_MS_PS / CCR_CLK_PS;
  localparam int CCR_SEC_MS = 1000;
  localparam logic [3:0][7:0] CCR_WD_S = {8'ha0, 8'h50, 8'h28, 8'h00};
  localparam logic [7:0] CCR_TERM_LONG_MS  = 8'he6; // 230
  localparam logic [7:0] CCR_TERM_SHORT_MS = 8'h10; // 16
  localparam int CCR_SHIP_DELAY_MS = 12300;
  localparam int CCR_HOUR_S = 3600;
  localparam int CCR_SAFE_SHORT_H = 7;
  localparam int CCR_SAFE_LONG_H = 16;
endpackage

//--- dv/ccr_host.sv
// host model: register port master and owner of the timeout kick bit
// assumes mclk from the bench; one access at a time, no overlap
`timescale 1ns/1ps
module ccr_host (
  input  logic       mclk,
  input  logic       host_timeout_kick_clear,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_wdata,
  output logic       host_timeout_kick
);
  // idle port, strobes low
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    host_timeout_kick = 1'b0;
  end

  // one write, held for the single edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a; // released lines must not keep the old value
    reg_wdata <= ~d;
  endtask

  // one read; data is judged by the bench one cycle later
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask

  // host sets the kick bit
  task automatic kick();
    @(posedge mclk);
    host_timeout_kick <= 1'b1;
  endtask

  // device acknowledges, bit falls back to 0
  always @(posedge mclk)
  begin
    if (host_timeout_kick_clear)
      host_timeout_kick <= 1'b0;
  end
endmodule

//--- dv/test_ccr_regs.sv
// self-checking bench of the charger configuration register bank
// assumes ccr_host drives the register port; timers shortened by parameters
`timescale 1ns/1ps
module test_ccr_regs;
  localparam logic [7:0]  RST_VAL [4] = '{8'h58, 8'h9f, 8'he6, 8'h4c};
  localparam logic [15:0] OVP_TAB [4] = '{16'h157c, 16'h1964, 16'h2904, 16'h36b0};
  localparam logic [15:0] BST_TAB [4] = '{16'h12f2, 16'h1388, 16'h141e, 16'h14b4};
  localparam logic [15:0] OFS_TAB [4] = '{16'h0f3c, 16'h170c, 16'h1d4c, 16'h2904};
  localparam logic [15:0] TRK_TAB [4] = '{16'h0000, 16'h00c8, 16'h00fa, 16'h012c};
  localparam logic [7:0]  STM_CTL [4] = '{8'h8b, 8'h8f, 8'h8b, 8'h8b};
  localparam logic [2:0]  STM_SLOW [4] = '{3'h0, 3'h0, 3'h4, 3'h1};
  localparam int          STM_CYC [4] = '{48, 96, 96, 96}; // one second is 16 cycles
  logic        mclk, reset_n, reg_reset, reg_wr, reg_rd, host_timeout_kick;
  logic        host_timeout_kick_clear, host_timeout_expired, charge_done, recharge_start;
  logic        term_condition, term_detected, direct_charge_path_enable, input_bus_overcurrent;
  logic        path_clear_req, charging_active, dynamic_power_limiting, cool_zone;
  logic        thermal_regulating, safety_timer_expired, cold_zone, cold_current_scale_enable;
  logic        warm_zone, vbus_present, input_limit_detect_done, input_limit_detect_run;
  logic        battery_switch_on;
  logic        rd_d;         // read taken at the last edge
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, thermal_limit_c;
  logic [11:0] fast_charge_current, charge_current_limit;
  logic [15:0] batt_mv, input_overvoltage_mv, boost_output_mv, charge_voltage_mv;
  logic [15:0] input_voltage_floor_mv, v, t, f;
  logic [1:0]  input_voltage_floor_offset_sel;
  logic [31:0] r;            // random scratch
  logic [7:0]  rd_q[$];      // expected read data, oldest first
  int          n_mismatch, num_checks, seed, cyc;

  ccr_regs #(.MS_CYCLES(4), .SEC_MS(4), .SHIP_MS(5), .SAFE_SHORT_S(3), .SAFE_LONG_S(6))
  i_ccr_regs (
    .mclk, .reset_n, .reg_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .host_timeout_kick, .host_timeout_kick_clear, .host_timeout_expired, .batt_mv,
    .charge_done, .recharge_start, .term_condition, .term_detected,
    .direct_charge_path_enable, .input_bus_overcurrent, .path_clear_req, .charging_active,
    .dynamic_power_limiting, .cool_zone, .thermal_regulating, .safety_timer_expired,
    .thermal_limit_c, .cold_zone, .cold_current_scale_enable, .fast_charge_current,
    .charge_current_limit, .input_overvoltage_mv, .boost_output_mv, .warm_zone,
    .charge_voltage_mv, .input_voltage_floor_offset_sel, .input_voltage_floor_mv,
    .vbus_present, .input_limit_detect_done, .input_limit_detect_run, .battery_switch_on
  );

  ccr_host host (
    .mclk, .host_timeout_kick_clear, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .host_timeout_kick
  );

  // 125 MHz
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // compare and count
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // bounded wait for a level; overrun ends the run
  task automatic wait_for(ref logic s, input logic lvl, input int n);
    cyc = 0;
    while (s !== lvl)
    begin
      @(posedge mclk);
      cyc++;
      if (cyc > n)
      begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask

  // note the expectation, then let the host read
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    host.rd(a);
  endtask

  // all four registers plus one unmapped place
  task automatic rd_all();
    for (int i = 0; i < 4; i++)
      rd(8'h04 + 8'(i), RST_VAL[i]);
    rd(8'h08, 8'h00);
  endtask

  // read data stands one cycle after the taken edge
  always @(posedge mclk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      check("reg_rdata", {8'h00, reg_rdata}, {8'h00, rd_q.pop_front()});
  end

  // main sequence
  initial
  begin
    seed = 32'hce4b;
    n_mismatch = 0;
    num_checks = 0;
    rd_d = 1'b0;
    {reset_n, reg_reset, charge_done, term_condition, warm_zone, vbus_present} = 6'h00;
    {direct_charge_path_enable, input_bus_overcurrent, charging_active} = 3'h0;
    {dynamic_power_limiting, cool_zone, thermal_regulating, cold_zone} = 4'h0;
    {cold_current_scale_enable, input_limit_detect_done} = 2'h0;
    batt_mv = 16'h0e10;
    fast_charge_current = 12'h000;
    input_voltage_floor_offset_sel = 2'h0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd_all();
    check("battery_switch_on", battery_switch_on, 1'b1);
    host.wr(8'h05, 8'h8f); // timeout off so later checks are not restored under us
    // every voltage code with random recharge select, battery and warm zone
    for (int n = 0; n < 32; n++)
    begin
      r = $random(seed);
      host.wr(8'h04, {5'(n), 2'b00, r[0]});
      warm_zone <= r[1];
      charge_done <= 1'b1;
      v = (n == 15) ? 16'h1100 : 16'h0f10 + 16'h0020 * 16'((n > 24) ? 24 : n);
      batt_mv <= v - 16'h00fa + {8'h00, r[15:8]};
      t = r[0] ? 16'h00c8 : 16'h0064; // select 0 reads as 100 mV
      @(posedge mclk);
      f = (r[1] && v > 16'h1004) ? 16'h1004 : v; // warm cap with select 0
      check("charge_voltage_mv", charge_voltage_mv, f);
      check("recharge_start", recharge_start, batt_mv < v - t);
      rd(8'h04, {5'(n), 2'b00, r[0]});
    end
    // input thresholds: every code of each field but random floor steps, random battery for tracking
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      r[7:4] = 4'(i);
      r[11:8] = ~4'(i);
      host.wr(8'h06, r[7:0]);
      host.wr(8'h07, {6'h12, r[9:8]});
      input_voltage_floor_offset_sel <= r[11:10];
      batt_mv <= 16'h0bb8 + {3'h0, r[24:12]};
      @(posedge mclk);
      f = OFS_TAB[r[11:10]] + 16'h0064 * {12'h000, r[3:0]};
      if (r[9:8] != 2'b00 && batt_mv + TRK_TAB[r[9:8]] > f)
        f = batt_mv + TRK_TAB[r[9:8]];
      check("input_voltage_floor_mv", input_voltage_floor_mv, f);
      check("input_overvoltage_mv", input_overvoltage_mv, OVP_TAB[r[7:6]]);
      check("boost_output_mv", boost_output_mv, BST_TAB[r[5:4]]);
      rd(8'h06, r[7:0]);
    end
    // thermal limit and cold zone scaling
    cold_zone <= 1'b1;
    cold_current_scale_enable <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      r = $random(seed);
      host.wr(8'h05, {6'h23, 2'(k)});
      fast_charge_current <= r[11:0];
      @(posedge mclk);
      check("thermal_limit_c", thermal_limit_c, k[1] ? 8'h78 : 8'h50);
      t = {4'h0, r[11:0] / (k[0] ? 12'h005 : 12'h002)}; // 20 or 50 percent
      check("charge_current_limit", charge_current_limit, t);
    end
    // shared bit: clear permission with path on, filter time with path off
    for (int s = 0; s < 2; s++)
    begin
      host.wr(8'h05, (s == 1) ? 8'hcf : 8'h8f);
      direct_charge_path_enable <= 1'b1;
      input_bus_overcurrent <= 1'b1;
      @(posedge mclk);
      check("path_clear_req", path_clear_req, s == 0);
      direct_charge_path_enable <= 1'b0;
      term_condition <= 1'b1;
      wait_for(term_detected, 1'b1, 1200);
      t = (s == 1) ? 16'h0040 : 16'h0398; // 16 ms or 230 ms at 4 cycles a ms
      check("term_filter", cyc >= t - 8 && cyc <= t + 8, 1'b1);
      host.wr(8'h05, (s == 1) ? 8'h4f : 8'h0f);
      wait_for(term_detected, 1'b0, 3);
      term_condition <= 1'b0;
      input_bus_overcurrent <= 1'b0;
    end
    // safety timer length and half rate while slowed
    for (int j = 0; j < 4; j++)
    begin
      host.wr(8'h05, STM_CTL[j]);
      {dynamic_power_limiting, cool_zone, thermal_regulating} <= STM_SLOW[j];
      charging_active <= 1'b1;
      wait_for(safety_timer_expired, 1'b1, 200);
      check("safety_timer", cyc >= STM_CYC[j] - 20 && cyc <= STM_CYC[j] + 30, 1'b1);
      charging_active <= 1'b0;
      wait_for(safety_timer_expired, 1'b0, 3);
    end
    // enable off: the timer must stay quiet well past its longest limit
    host.wr(8'h05, 8'h83);
    charging_active <= 1'b1;
    repeat (200) @(posedge mclk);
    check("safety_timer_off", safety_timer_expired, 1'b0);
    charging_active <= 1'b0;
    // forced detection runs with input present, device clears it when done
    host.wr(8'h07, 8'hc8);
    @(posedge mclk);
    check("input_limit_detect_run", input_limit_detect_run, 1'b0);
    vbus_present <= 1'b1;
    @(posedge mclk);
    check("input_limit_detect_run", input_limit_detect_run, 1'b1);
    input_limit_detect_done <= 1'b1;
    @(posedge mclk);
    input_limit_detect_done <= 1'b0;
    rd(8'h07, 8'h48);
    // battery switch: immediate, back on, then after the ship delay
    host.wr(8'h07, 8'h20);
    wait_for(battery_switch_on, 1'b0, 3);
    host.wr(8'h07, 8'h08);
    wait_for(battery_switch_on, 1'b1, 3);
    host.wr(8'h07, 8'h28);
    wait_for(battery_switch_on, 1'b0, 40);
    check("switch_delay", cyc >= 14 && cyc <= 26, 1'b1);
    // timeout periods, kick, and what expiry restores
    for (int c = 1; c < 4; c++)
    begin
      host.wr(8'h04, 8'h21);
      host.wr(8'h06, 8'h15);
      host.wr(8'h07, 8'h2b);
      host.wr(8'h05, {2'b10, 2'(c), 4'hf});
      host.kick();
      @(posedge mclk);
      wait_for(host_timeout_kick, 1'b0, 4);
      wait_for(host_timeout_expired, 1'b1, 3000);
      t = 16'(640 << (c - 1)); // 40 s doubles per code, 16 cycles a second
      check("timeout_period", cyc >= t - 24 && cyc <= t + 24, 1'b1);
      @(posedge mclk);
      rd(8'h04, 8'h58);
      rd(8'h05, 8'h9f);
      rd(8'h06, 8'h15);
      rd(8'h07, 8'h6f);
    end
    // register reset restores everything
    reg_reset <= 1'b1;
    @(posedge mclk);
    reg_reset <= 1'b0;
    rd_all();
    repeat (3) @(posedge mclk);
    finish_test();
  end
endmodule
